// ---- pkg/qet_defs.vh ----
// Constants for the quadrature encoder trigger block
// Included by the ratio generator and the top of the block; definitions only
`ifndef QET_DEFS_VH
`define QET_DEFS_VH
`define QET_DIV_W 24
`define QET_DIV_DEFAULT 24'h010000
`define QET_DIV_UNIT_LSB 16
`define QET_SKIP_W 8
`define QET_SKIP_DEFAULT 8'h00
`define QET_MASK_W 16
`define QET_MODE_MOTION 2'h0
`define QET_MODE_FWD 2'h1
`define QET_MODE_REV 2'h2
`define QET_OPT_RATIO 1'b0
`define QET_OPT_SKIP 1'b1
`define QET_TIMER_W 24
`endif

// ---- src/qet_quad_decoder.v ----
// Quadrature decoder: four-state machine giving one signed step per valid edge
// Assumes phase inputs already synchronised to clk
`timescale 1ns/10ps
`default_nettype none
module qet_quad_decoder (
  input wire clk,
  input wire reset_n,
  input wire phase_a,
  input wire phase_b,
  output reg step,
  output reg step_dir,
  output reg a_rise
);
  reg [1:0] prev;
  wire [1:0] cur = {phase_a, phase_b};
  // Gray order 00,01,11,10 is one direction
  function [1:0] qet_gray_idx;
    input [1:0] s;
    begin
      case (s)
        2'h0: qet_gray_idx = 2'h0;
        2'h1: qet_gray_idx = 2'h1;
        2'h3: qet_gray_idx = 2'h2;
        default: qet_gray_idx = 2'h3;
      endcase
    end
  endfunction
  wire [1:0] diff = qet_gray_idx(cur) - qet_gray_idx(prev);
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      prev <= 2'h0;
      step <= 1'b0;
      step_dir <= 1'b0;
      a_rise <= 1'b0;
    end else begin
      prev <= cur;
      a_rise <= cur[1] & ~prev[1];
      // Double transitions (diff 2) are ignored
      step <= (diff == 2'h1) | (diff == 2'h3);
      // A leads B walks 00,10,11,01 and gives diff 3 (forward); B leading gives diff 1
      if (diff == 2'h3)
        step_dir <= 1'b1;
      else if (diff == 2'h1)
        step_dir <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// ---- src/qet_ratio_gen.v ----
// Ratio trigger generator: decimation for nonzero multiples of 65536, interval synthesis otherwise
// Assumes a one-cycle pulse per channel A rising edge on clk
`timescale 1ns/10ps
`default_nettype none
`include "qet_defs.vh"
module qet_ratio_gen #(
  parameter DIV_W = `QET_DIV_W,
  parameter TIMER_W = `QET_TIMER_W
) (
  input wire clk,
  input wire reset_n,
  input wire clear,
  input wire [DIV_W-1:0] divisor,
  input wire in_pulse,
  output reg trig
);
  wire [15:0] frac = divisor[`QET_DIV_UNIT_LSB-1:0];
  wire [DIV_W-17:0] mult = divisor[DIV_W-1:`QET_DIV_UNIT_LSB];
  wire is_decim = (frac == 16'h0000) && (mult != 0);
  reg [DIV_W-17:0] dec_cnt;
  reg [TIMER_W-1:0] period;
  reg [TIMER_W-1:0] meas;
  reg [TIMER_W+DIV_W-1:0] acc;
  localparam ACC_W = TIMER_W + DIV_W;
  // Each cycle adds one unit of 65536; a trigger is due once period*divisor is reached
  wire [ACC_W-1:0] unit = {{(ACC_W-17){1'b0}}, 17'h10000};
  wire [ACC_W-1:0] thresh = {{DIV_W{1'b0}}, period} * {{TIMER_W{1'b0}}, divisor};
  wire [ACC_W-1:0] acc_inc = acc + unit;
  // First pulse after a clear only starts the interval measurement
  reg primed;
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      dec_cnt <= {(DIV_W-16){1'b0}};
      period <= {TIMER_W{1'b0}};
      meas <= {TIMER_W{1'b0}};
      acc <= {ACC_W{1'b0}};
      primed <= 1'b0;
      trig <= 1'b0;
    end else begin
      trig <= 1'b0;
      if (clear) begin
        dec_cnt <= {(DIV_W-16){1'b0}};
        period <= {TIMER_W{1'b0}};
        meas <= {TIMER_W{1'b0}};
        acc <= {ACC_W{1'b0}};
        primed <= 1'b0;
      end else if (is_decim) begin
        // Every mult-th pulse fires: 65536 gives 1:1, 131072 gives 2:1
        if (in_pulse) begin
          if (dec_cnt + 1'b1 >= mult) begin
            dec_cnt <= {(DIV_W-16){1'b0}};
            trig <= 1'b1;
          end else begin
            dec_cnt <= dec_cnt + 1'b1;
          end
        end
      end else begin
        // Triggers spaced period*divisor/65536 cycles apart
        if (meas != {TIMER_W{1'b1}})
          meas <= meas + 1'b1;
        if (in_pulse) begin
          if (primed)
            period <= meas;
          primed <= 1'b1;
          meas <= {TIMER_W{1'b0}};
        end
        if (period != {TIMER_W{1'b0}}) begin
          if (acc_inc >= thresh) begin
            acc <= acc_inc - thresh;
            trig <= 1'b1;
          end else begin
            acc <= acc_inc;
          end
        end
      end
    end
  end
endmodule
`default_nettype wire

// ---- src/qet_encoder_trigger.v ----
// Top of the quadrature encoder trigger block: decode, trigger modes, reverse masking
// Phase pins asynchronous; controls static from the same clock
`timescale 1ns/10ps
`default_nettype none
`include "qet_defs.vh"
module qet_encoder_trigger #(
  parameter DIV_W = `QET_DIV_W,
  parameter SKIP_W = `QET_SKIP_W,
  parameter MASK_W = `QET_MASK_W
) (
  input wire CLOCK,
  input wire RESET_N,
  input wire PHASE_A,
  input wire PHASE_B,
  input wire [DIV_W-1:0] TRIGGER_RATIO_DIVISOR,
  input wire EDGE_SKIP_OPTION,
  input wire [SKIP_W-1:0] EDGE_SKIP_COUNT,
  input wire [1:0] OUTPUT_DIRECTION_MODE,
  input wire TRAVEL_SENSE_SELECT,
  input wire CAPTURE_BEGIN_CMD,
  output reg LINE_TRIGGER,
  output reg OUTPUT_PAUSED,
  output reg DIRECTION,
  output reg [MASK_W-1:0] REVERSE_MASK_COUNTER
);
  reg [1:0] sync_a;
  reg [1:0] sync_b;
  wire step;
  wire step_dir;
  wire a_rise;
  wire ratio_trig;
  reg [SKIP_W-1:0] skip_cnt;
  reg skip_trig;
  always @(posedge CLOCK or negedge RESET_N) begin
    if (!RESET_N) begin
      sync_a <= 2'h0;
      sync_b <= 2'h0;
    end else begin
      sync_a <= {sync_a[0], PHASE_A};
      sync_b <= {sync_b[0], PHASE_B};
    end
  end
  qet_quad_decoder u_dec (
    .clk(CLOCK),
    .reset_n(RESET_N),
    .phase_a(sync_a[1]),
    .phase_b(sync_b[1]),
    .step(step),
    .step_dir(step_dir),
    .a_rise(a_rise)
  );
  qet_ratio_gen #(.DIV_W(DIV_W)) u_ratio (
    .clk(CLOCK),
    .reset_n(RESET_N),
    .clear(CAPTURE_BEGIN_CMD),
    .divisor(TRIGGER_RATIO_DIVISOR),
    .in_pulse(a_rise),
    .trig(ratio_trig)
  );
  // Edge-skip: every decoded edge is one input pulse, four per A period
  always @(posedge CLOCK or negedge RESET_N) begin
    if (!RESET_N) begin
      skip_cnt <= `QET_SKIP_DEFAULT;
      skip_trig <= 1'b0;
    end else begin
      skip_trig <= 1'b0;
      if (CAPTURE_BEGIN_CMD) begin
        skip_cnt <= `QET_SKIP_DEFAULT;
      end else if (step) begin
        if (skip_cnt >= EDGE_SKIP_COUNT) begin
          skip_cnt <= `QET_SKIP_DEFAULT;
          skip_trig <= 1'b1;
        end else begin
          skip_cnt <= skip_cnt + 1'b1;
        end
      end
    end
  end
  // Forward after travel sense applied
  wire fwd = step_dir ^ TRAVEL_SENSE_SELECT;
  wire mode_fwd = (OUTPUT_DIRECTION_MODE == `QET_MODE_FWD);
  wire mode_rev = (OUTPUT_DIRECTION_MODE == `QET_MODE_REV);
  wire masking = mode_fwd | mode_rev;
  wire wanted = mode_fwd ? fwd : ~fwd;
  wire raw_trig = (EDGE_SKIP_OPTION == `QET_OPT_SKIP) ? skip_trig : ratio_trig;
  wire cnt_zero = (REVERSE_MASK_COUNTER == {MASK_W{1'b0}});
  wire [MASK_W-1:0] cnt_max = {MASK_W{1'b1}};
  reg [MASK_W-1:0] next_count;
  always @* begin
    next_count = REVERSE_MASK_COUNTER;
    if (CAPTURE_BEGIN_CMD)
      next_count = {MASK_W{1'b0}};
    else if (!masking)
      next_count = {MASK_W{1'b0}};
    else if (step && !wanted && REVERSE_MASK_COUNTER != cnt_max)
      next_count = REVERSE_MASK_COUNTER + 1'b1;
    else if (step && wanted && !cnt_zero)
      next_count = REVERSE_MASK_COUNTER - 1'b1;
  end
  // In forward or reverse mode, output allowed only while moving in the wanted direction with zero count
  wire gate_ok = !masking || (cnt_zero && wanted && !(step && !wanted));
  always @(posedge CLOCK or negedge RESET_N) begin
    if (!RESET_N) begin
      REVERSE_MASK_COUNTER <= {MASK_W{1'b0}};
      LINE_TRIGGER <= 1'b0;
      OUTPUT_PAUSED <= 1'b0;
      DIRECTION <= 1'b0;
    end else begin
      REVERSE_MASK_COUNTER <= next_count;
      LINE_TRIGGER <= raw_trig && gate_ok && !CAPTURE_BEGIN_CMD;
      OUTPUT_PAUSED <= masking && (next_count != {MASK_W{1'b0}} || (step && !wanted));
      DIRECTION <= fwd;
    end
  end
endmodule
`default_nettype wire

// ---- sim/qet_encoder_trigger_properties.sv ----
// Checker for the encoder trigger top: trigger and masking relations
// Bound to the top below; sees its ports only
`timescale 1ns/10ps
`default_nettype none
module qet_encoder_trigger_properties #(
  parameter SKIP_W = 8,
  parameter MASK_W = 16
) (
  input wire CLOCK,
  input wire RESET_N,
  input wire PHASE_A,
  input wire PHASE_B,
  input wire EDGE_SKIP_OPTION,
  input wire [SKIP_W-1:0] EDGE_SKIP_COUNT,
  input wire [1:0] OUTPUT_DIRECTION_MODE,
  input wire CAPTURE_BEGIN_CMD,
  input wire LINE_TRIGGER,
  input wire OUTPUT_PAUSED,
  input wire DIRECTION,
  input wire [MASK_W-1:0] REVERSE_MASK_COUNTER
);
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RESET_N);
  wire [MASK_W-1:0] cnt = REVERSE_MASK_COUNTER;
  wire [1:0] m = OUTPUT_DIRECTION_MODE;
  AST_CAP_CLEAR: assert property (CAPTURE_BEGIN_CMD |=> cnt == 0) else $error("count kept");
  AST_MOTION: assert property ((m == 2'h0) [*2] |-> cnt == 0 && !OUTPUT_PAUSED) else $error("masked");
  AST_HOLD: assert property (cnt != 0 |-> OUTPUT_PAUSED) else $error("count unpaused");
  AST_STEP: assert property ($changed(cnt) && cnt != 0 |-> cnt == $past(cnt) + 1'b1 || cnt == $past(cnt) - 1'b1)
    else $error("count jumped");
  AST_UP_REV: assert property (m == 2'h1 && cnt > $past(cnt) |-> !DIRECTION) else $error("up forward");
  AST_NO_TRIG: assert property (LINE_TRIGGER |-> !OUTPUT_PAUSED) else $error("trigger paused");
  AST_PULSE: assert property (LINE_TRIGGER |=> !LINE_TRIGGER) else $error("trigger stuck");
  AST_EACH_EDGE: assert property (EDGE_SKIP_OPTION && EDGE_SKIP_COUNT == 0 && m == 2'h0 &&
    ($changed(PHASE_A) || $changed(PHASE_B)) |-> ##[3:6] LINE_TRIGGER) else $error("edge missed");
  cover property (LINE_TRIGGER && EDGE_SKIP_OPTION);
  cover property ($rose(OUTPUT_PAUSED));
  cover property ($fell(OUTPUT_PAUSED));
endmodule
bind qet_encoder_trigger qet_encoder_trigger_properties #(.SKIP_W(SKIP_W), .MASK_W(MASK_W)) chk_u (.*);
`default_nettype wire

// ---- sim/qet_encoder_model.sv ----
// Encoder model: two phases in exact quadrature
// Steps when the bench calls move; levels hold between moves
`timescale 1ns/10ps
`default_nettype none
module qet_encoder_model (
  input wire logic CLOCK,
  output logic PHASE_A,
  output logic PHASE_B
);
  logic [1:0] pos = 2'h0;
  assign PHASE_A = pos[1] ^ pos[0];
  assign PHASE_B = pos[1];
  // Forward lets A lead B; eight clocks per step
  task automatic move(input int n, input logic fwd);
    repeat (n) begin
      @(posedge CLOCK);
      pos <= fwd ? pos + 2'h1 : pos - 2'h1;
      repeat (7) @(posedge CLOCK);
    end
  endtask
endmodule
`default_nettype wire

// ---- sim/qet_encoder_trigger_test.sv ----
// Bench for the encoder trigger top: ratio, edge-skip, masking, direction
// Phases come from the encoder model; the checker is bound to the top
`timescale 1ns/10ps
`default_nettype none
module qet_encoder_trigger_test;
  logic clock, reset_n, pha, phb, opt, cap, sense, trig, paused, dir;
  logic [23:0] div;
  logic [7:0] skip;
  logic [1:0] mode;
  logic [15:0] mask;
  int bad_count = 0;
  int samples_checked = 0;
  int hits = 0;
  qet_encoder_trigger dut_u (.CLOCK(clock), .RESET_N(reset_n), .PHASE_A(pha), .PHASE_B(phb),
    .TRIGGER_RATIO_DIVISOR(div), .EDGE_SKIP_OPTION(opt), .EDGE_SKIP_COUNT(skip), .OUTPUT_DIRECTION_MODE(mode),
    .TRAVEL_SENSE_SELECT(sense), .CAPTURE_BEGIN_CMD(cap), .LINE_TRIGGER(trig), .OUTPUT_PAUSED(paused),
    .DIRECTION(dir), .REVERSE_MASK_COUNTER(mask));
  qet_encoder_model enc_u (.CLOCK(clock), .PHASE_A(pha), .PHASE_B(phb));
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  always @(posedge clock) if (trig === 1'b1) hits++;
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch %s expected %0h seen %0h", what, exp, seen);
    end
  endtask
  // Applies settings with a capture pulse, then clears the trigger tally
  task automatic cfg(input logic o, input logic [7:0] k, input logic [23:0] d, input logic [1:0] m, input logic s);
    @(posedge clock);
    opt <= o;
    skip <= k;
    div <= d;
    mode <= m;
    sense <= s;
    cap <= 1'b1;
    @(posedge clock);
    cap <= 1'b0;
    @(negedge clock) hits = 0;
  endtask
  task automatic ratio_test();
    cfg(1'b0, 8'h00, 24'h010000, 2'h0, 1'b0);
    enc_u.move(24, 1'b1);
    check("ratio 1:1", hits, 6);
    cfg(1'b0, 8'h00, 24'h020000, 2'h0, 1'b0);
    enc_u.move(24, 1'b1);
    check("ratio 2:1", hits, 3);
    cfg(1'b0, 8'h00, 24'h008000, 2'h0, 1'b0);
    enc_u.move(24, 1'b1);
    check("ratio 1:2", hits >= 7, 1);
  endtask
  task automatic skip_test();
    for (int k = 0; k < 3; k++) begin
      cfg(1'b1, k[7:0], 24'h010000, 2'h0, 1'b0);
      enc_u.move(12, 1'b1);
      check("edge skip", hits, 12 / (k + 1));
    end
  endtask
  // Reversal against the wanted direction w, return, resume, then clear
  task automatic mask_test(input logic [1:0] m, input logic w);
    cfg(1'b1, 8'h00, 24'h010000, m, 1'b0);
    enc_u.move(3, !w);
    check("mask up", {paused, hits[3:0], mask}, {1'b1, 4'h0, 16'h0003});
    check("direction", dir, !w);
    enc_u.move(2, w);
    check("mask down", {paused, mask}, {1'b1, 16'h0001});
    enc_u.move(1, w);
    @(negedge clock) hits = 0;
    enc_u.move(2, w);
    check("resumed", {paused, hits[3:0], mask}, {1'b0, 4'h2, 16'h0000});
    enc_u.move(2, !w);
    cfg(1'b1, 8'h00, 24'h010000, m, 1'b0);
    check("mask cleared", mask, 0);
  endtask
  task automatic sense_test();
    cfg(1'b1, 8'h00, 24'h010000, 2'h0, 1'b1);
    enc_u.move(4, 1'b1);
    check("sensed direction", dir, 0);
    enc_u.move(4, 1'b0);
    check("both ways", {paused, hits[3:0], mask}, {1'b0, 4'h8, 16'h0000});
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  initial begin
    {reset_n, opt, cap, sense, mode, skip} = 14'h0000;
    div = 24'h010000;
    repeat (8) @(posedge clock);
    reset_n <= 1'b1;
    ratio_test();
    skip_test();
    mask_test(2'h1, 1'b1);
    mask_test(2'h2, 1'b0);
    sense_test();
    wrap_up();
  end
  initial begin
    #200000;
    bad_count++;
    wrap_up();
  end
endmodule
`default_nettype wire
